// *** core/char_lcd_core.sv ***
// Host register port, display and glyph RAM, and screen readout
`timescale 1ns/10ps
`default_nettype none

module char_lcd_core #(
    parameter int BUSY_LEN = char_lcd_pkg::BUSY_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_register_select,
    input wire logic i_read_write,
    input wire logic i_enable,
    input wire logic [7:0] i_data_in,
    output logic [7:0] o_data_out,
    output logic o_data_oe,
    input wire logic i_scan_line,
    input wire logic [3:0] i_scan_col,
    input wire logic [2:0] i_scan_row,
    input wire logic i_cursor_on,
    output logic [4:0] o_pixel_row
);
    import char_lcd_pkg::*;

    // --------------------------------------------------------------
    // Parameter check
    // --------------------------------------------------------------
    generate
        if (BUSY_LEN < 1 || BUSY_LEN > 255) begin : g_bad_busy
            $error("BUSY_LEN must lie in 1..255");
        end
    endgenerate

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic [10:0] sync1_reg;
    logic [10:0] sync2_reg;
    logic enable_prev_reg;
    logic rs_hold_reg;
    logic rw_hold_reg;
    logic [7:0] data_hold_reg;
    core_state_t state_reg;
    core_op_t op_reg;
    logic [7:0] count_reg;
    logic [6:0] address_counter_reg;
    logic user_glyph_sel_reg;
    logic inc_reg;
    logic [5:0] shift_reg;
    logic [7:0] data_buffer_register_reg;
    logic [7:0] display_ram [DD_DEPTH];
    logic [7:0] user_glyph_ram [CG_DEPTH];

    logic enable_s;
    logic rs_s;
    logic rw_s;
    logic fall_evt;
    logic idle;
    logic busy_flag;
    logic op_done;
    logic instr_evt;
    logic [6:0] ac_step;
    logic [7:0] ram_byte;
    logic [7:0] ram_next;
    logic [6:0] scan_low;
    logic [6:0] scan_addr;
    logic [7:0] scan_code;
    logic [7:0] scan_user_byte;
    logic [4:0] pixels_next;

    // --------------------------------------------------------------
    // Address helpers
    // --------------------------------------------------------------
    // Fold the two 40-byte line ranges onto one 80-byte array
    function automatic logic [6:0] dd_index(input logic [6:0] a);
        logic [6:0] low;
        low = {1'b0, a[5:0]};
        if (low >= 7'(LINE_LEN)) begin
            low = low - 7'(LINE_LEN);
        end
        return a[6] ? low + 7'(LINE_LEN) : low;
    endfunction

    // One step of the counter, wrapping line one into line two and back
    function automatic logic [6:0] step_ac(input logic [6:0] a,
                                           input logic up,
                                           input logic glyph);
        logic [6:0] r;
        r = 7'h00;
        if (glyph) begin
            r = up ? {1'b0, a[5:0] + 6'h01} : {1'b0, a[5:0] - 6'h01};
        end else if (up) begin
            if (a == LINE1_LAST) begin
                r = LINE2_FIRST;
            end else if (a == LINE2_LAST) begin
                r = LINE1_FIRST;
            end else begin
                r = a + 7'h01;
            end
        end else begin
            if (a == LINE1_FIRST) begin
                r = LINE2_LAST;
            end else if (a == LINE2_FIRST) begin
                r = LINE1_LAST;
            end else begin
                r = a - 7'h01;
            end
        end
        return r;
    endfunction

    // --------------------------------------------------------------
    // Pin synchronisers and strobe edge
    // --------------------------------------------------------------
    // Bus pins are asynchronous to i_clk; two stages before any use
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_reg <= 11'h000;
            sync2_reg <= 11'h000;
            enable_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {i_enable, i_register_select, i_read_write,
                          i_data_in};
            sync2_reg <= sync1_reg;
            enable_prev_reg <= sync2_reg[10];
        end
    end

    assign enable_s = sync2_reg[10];
    assign rs_s = sync2_reg[9];
    assign rw_s = sync2_reg[8];
    assign fall_evt = enable_prev_reg & ~enable_s;

    // Keep the last values seen while the strobe was high; data may
    // drop soon after the fall, so the fall uses these copies
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rs_hold_reg <= 1'b0;
            rw_hold_reg <= 1'b0;
            data_hold_reg <= 8'h00;
        end else if (enable_s) begin
            rs_hold_reg <= rs_s;
            rw_hold_reg <= rw_s;
            data_hold_reg <= sync2_reg[7:0];
        end
    end

    // --------------------------------------------------------------
    // Busy sequencing
    // --------------------------------------------------------------
    assign idle = (state_reg == ST_IDLE);
    assign busy_flag = (state_reg == ST_BUSY);
    assign op_done = busy_flag && (count_reg == 8'h00);
    assign instr_evt = fall_evt && !rs_hold_reg && !rw_hold_reg;

    // Every accepted access except a status read starts one fixed-length internal operation
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_NONE;
            count_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (fall_evt && !(!rs_hold_reg && rw_hold_reg)) begin
                        state_reg <= ST_BUSY; // RL23
                        count_reg <= 8'(BUSY_LEN - 1);
                        if (!rs_hold_reg) begin
                            if (data_hold_reg[INS_DD_ADDR_BIT] ||
                                data_hold_reg[INS_CG_ADDR_BIT]) begin
                                op_reg <= OP_LOAD; // RL3
                            end else begin
                                op_reg <= OP_NONE;
                            end
                        end else if (!rw_hold_reg) begin
                            op_reg <= OP_WRITE; // RL2
                        end else begin
                            op_reg <= OP_NEXT; // RL4
                        end
                    end
                end
                ST_BUSY: begin
                    // Accesses arriving now are dropped, not queued
                    if (count_reg == 8'h00) begin
                        state_reg <= ST_IDLE; // RL6 RL23
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Instruction register effects
    // --------------------------------------------------------------
    assign ac_step = step_ac(address_counter_reg, inc_reg,
                             user_glyph_sel_reg);

    // Mode and shift settle only on an accepted instruction write
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            inc_reg <= ENTRY_INC_RESET;
            shift_reg <= SHIFT_RESET;
        end else if (instr_evt && idle) begin // RL1 RL6
            if (data_hold_reg[7:5] == 3'b000 &&
                data_hold_reg[INS_SHIFT_BIT] &&
                data_hold_reg[SHIFT_DISPLAY_BIT]) begin
                if (data_hold_reg[SHIFT_RIGHT_BIT]) begin
                    shift_reg <= (shift_reg == 6'h00) ?
                        6'(LINE_LEN - 1) : shift_reg - 6'h01; // RL14
                end else begin
                    shift_reg <= (shift_reg == 6'(LINE_LEN - 1)) ?
                        6'h00 : shift_reg + 6'h01; // RL13
                end
            end else if (data_hold_reg[7:3] == 5'b00000 &&
                         data_hold_reg[INS_ENTRY_BIT]) begin
                inc_reg <= data_hold_reg[ENTRY_INC_BIT]; // RL9
            end
        end
    end

    // Counter: address loads, cursor moves and post-access steps
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            address_counter_reg <= AC_RESET;
            user_glyph_sel_reg <= 1'b0;
        end else if (instr_evt && idle) begin
            if (data_hold_reg[INS_DD_ADDR_BIT]) begin
                address_counter_reg <= data_hold_reg[6:0]; // RL8
                user_glyph_sel_reg <= 1'b0;
            end else if (data_hold_reg[INS_CG_ADDR_BIT]) begin
                address_counter_reg <= {1'b0, data_hold_reg[5:0]}; // RL8
                user_glyph_sel_reg <= 1'b1;
            end else if (data_hold_reg[7:5] == 3'b000 &&
                         data_hold_reg[INS_SHIFT_BIT] &&
                         !data_hold_reg[SHIFT_DISPLAY_BIT]) begin
                address_counter_reg <= data_hold_reg[SHIFT_RIGHT_BIT] ?
                    step_ac(address_counter_reg, 1'b1, user_glyph_sel_reg) :
                    step_ac(address_counter_reg, 1'b0, user_glyph_sel_reg);
            end
        end else if (op_done && (op_reg == OP_WRITE || op_reg == OP_NEXT)) begin
            address_counter_reg <= ac_step; // RL9
        end
    end

    // --------------------------------------------------------------
    // RAM transfers
    // --------------------------------------------------------------
    assign ram_byte = user_glyph_sel_reg ?
        user_glyph_ram[address_counter_reg[5:0]] :
        display_ram[dd_index(address_counter_reg)];
    assign ram_next = user_glyph_sel_reg ?
        user_glyph_ram[ac_step[5:0]] :
        display_ram[dd_index(ac_step)];

    // Buffer takes host writes at once, RAM bytes at the end of an op
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            data_buffer_register_reg <= BUFFER_RESET;
        end else if (fall_evt && idle && rs_hold_reg && !rw_hold_reg) begin
            data_buffer_register_reg <= data_hold_reg; // RL1
        end else if (op_done && op_reg == OP_LOAD) begin
            data_buffer_register_reg <= ram_byte; // RL3
        end else if (op_done && op_reg == OP_NEXT) begin
            data_buffer_register_reg <= ram_next; // RL4
        end
    end

    // Storage keeps all eight bits, so hidden bytes serve as plain RAM
    always_ff @(posedge i_clk) begin
        if (op_done && op_reg == OP_WRITE) begin
            if (user_glyph_sel_reg) begin
                user_glyph_ram[address_counter_reg[5:0]] <=
                    data_buffer_register_reg; // RL2 RL16
            end else begin
                display_ram[dd_index(address_counter_reg)] <=
                    data_buffer_register_reg; // RL2 RL11
            end
        end
    end

    // --------------------------------------------------------------
    // Host read data
    // --------------------------------------------------------------
    // Drive the bus only while the strobe is high on a read
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_data_out <= 8'h00;
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= enable_s && rw_s;
            if (rs_s) begin
                o_data_out <= data_buffer_register_reg; // RL5
            end else begin
                o_data_out <= {busy_flag, address_counter_reg}; // RL10
            end
        end
    end

    // --------------------------------------------------------------
    // Screen readout
    // --------------------------------------------------------------
    // Position plus shift, taken modulo the 40-byte line
    always_comb begin
        scan_low = 7'(i_scan_col) + 7'(shift_reg);
        if (scan_low >= 7'(LINE_LEN)) begin
            scan_low = scan_low - 7'(LINE_LEN);
        end
        scan_addr = {i_scan_line, scan_low[5:0]}; // RL12 RL13 RL14
    end

    assign scan_code = display_ram[dd_index(scan_addr)];
    assign scan_user_byte =
        user_glyph_ram[{scan_code[2:0], i_scan_row}]; // RL20 RL22

    glyph_row_select u_glyph_row (
        .i_code(scan_code),
        .i_row(i_scan_row),
        .i_user_byte(scan_user_byte),
        .i_cursor_on(i_cursor_on),
        .o_pixels(pixels_next)
    );

    // Registered so the pixel output is glitch free
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pixel_row <= 5'h00;
        end else begin
            o_pixel_row <= pixels_next;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    localparam int BUSY_WAIT = BUSY_LEN + 1;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_write_done;
        op_done && op_reg == OP_WRITE && !user_glyph_sel_reg;
    endsequence

    sequence s_next_done;
        op_done && op_reg == OP_NEXT;
    endsequence

    a_busy_refuses_instr: assert property ( // RL6
        busy_flag && instr_evt |=> $stable(inc_reg) && $stable(shift_reg))
        else $error("instruction taken while busy");

    a_busy_ends_bounded: assert property ( // RL23
        $rose(busy_flag) |-> ##[1:BUSY_WAIT] idle)
        else $error("busy flag did not clear in time");

    a_write_lands_ram: assert property ( // RL2
        s_write_done |=> display_ram[dd_index($past(address_counter_reg))]
            == $past(data_buffer_register_reg))
        else $error("data write missing from display RAM");

    a_prefetch_loads_buffer: assert property ( // RL3
        op_done && op_reg == OP_LOAD |=>
            data_buffer_register_reg == $past(ram_byte))
        else $error("address write did not prefetch");

    a_read_next_step: assert property ( // RL4
        s_next_done |=> address_counter_reg == $past(ac_step) &&
            data_buffer_register_reg == $past(ram_next))
        else $error("read did not advance to next byte");

    a_addr_instr_load: assert property ( // RL8
        instr_evt && idle && data_hold_reg[INS_DD_ADDR_BIT] |=>
            address_counter_reg == $past(data_hold_reg[6:0]) &&
            !user_glyph_sel_reg && busy_flag)
        else $error("address instruction not loaded");

    a_status_read_bits: assert property ( // RL10
        enable_s && rw_s && !rs_s |=> o_data_oe &&
            o_data_out == {$past(busy_flag), $past(address_counter_reg)})
        else $error("status byte wrong");

    a_scan_no_shift: assert property ( // RL12
        shift_reg == 6'h00 |-> scan_addr == {i_scan_line, 2'b00, i_scan_col})
        else $error("unshifted screen map wrong");

    a_scan_right_wrap: assert property ( // RL14
        shift_reg == 6'(LINE_LEN - 1) && i_scan_col == 4'h0 |->
            scan_addr == (i_scan_line ? LINE2_LAST : LINE1_LAST))
        else $error("right shift wrap wrong");

    a_user_glyph_row: assert property ( // RL17
        scan_code[7:4] == 4'h0 && i_scan_row != CURSOR_ROW |=>
            o_pixel_row == $past(scan_user_byte[4:0]))
        else $error("user glyph row not shown");

endmodule // char_lcd_core

`default_nettype wire

// *** core/char_lcd_pkg.sv ***
// Constants and glyph row selector for the character display register core
//
// Behaviour
// [RL1] Two 8-bit host registers: write-only instruction, read/write data buffer.
// [RL2] A data write is copied into display or glyph RAM at the counter.
// [RL3] An address write prefetches the addressed RAM byte into the buffer.
// [RL4] After each data read the byte at the next address is loaded.
// [RL5] Select pair: 00 instr write, 01 status read, 10 data write, 11 data read.
// [RL6] During an internal operation busy reads 1 and instructions are refused.
// [RL7] Host waits for busy at 0 before the next instruction write.
// [RL8] Address instruction loads the counter and picks display or glyph RAM.
// [RL9] Each RAM data access steps the counter by one, up or down per mode.
// [RL10] Status read gives busy on bit 7 and the counter on bits 6..0.
// [RL11] Display RAM holds 80 bytes; unseen bytes stay usable as storage.
// [RL12] Unshifted, line one starts at 00H and line two at 40H.
// [RL13] After left shift each position shows the next address, 01H and 41H.
// [RL14] After right shift position one shows 27H and 67H.
// [RL15] Glyph ROM turns 8-bit codes into dot patterns.
// [RL16] 64-byte user glyph RAM; unused bytes stay usable as storage.
// [RL17] Codes 00H..07H pick user glyph RAM instead of glyph ROM.
// [RL18] Only the low five bits of a glyph RAM row are shown.
// [RL19] Host writes glyph rows by auto increment, then resets a display address.
// [RL20] Glyph RAM address is code bits 2..0 above the row number.
// [RL21] The eighth glyph row is shown ORed with the cursor.
// [RL22] Code bit 3 is ignored, so 00H and 08H show the same glyph.
// [RL23] Busy is held during every internal RAM transfer, cleared when done.

package char_lcd_pkg;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 20;
    localparam int OP_TIME_NS = 1000;
    localparam int BUSY_CYCLES = (OP_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

    // --------------------------------------------------------------
    // Instruction fields
    // --------------------------------------------------------------
    localparam int INS_DD_ADDR_BIT = 7;
    localparam int INS_CG_ADDR_BIT = 6;
    localparam int INS_SHIFT_BIT = 4;
    localparam int INS_ENTRY_BIT = 2;
    localparam int SHIFT_DISPLAY_BIT = 3;
    localparam int SHIFT_RIGHT_BIT = 2;
    localparam int ENTRY_INC_BIT = 1;
    localparam logic ENTRY_INC_RESET = 1'b1;

    // --------------------------------------------------------------
    // Memory layout
    // --------------------------------------------------------------
    localparam int DD_DEPTH = 80;
    localparam int CG_DEPTH = 64;
    localparam int LINE_LEN = 40;
    localparam int DISP_COLS = 16;
    localparam logic [6:0] LINE1_FIRST = 7'h00;
    localparam logic [6:0] LINE1_LAST = 7'h27;
    localparam logic [6:0] LINE2_FIRST = 7'h40;
    localparam logic [6:0] LINE2_LAST = 7'h67;
    localparam logic [2:0] CURSOR_ROW = 3'h7;
    localparam logic [5:0] SHIFT_RESET = 6'h00;
    localparam logic [7:0] BUFFER_RESET = 8'h00;
    localparam logic [6:0] AC_RESET = 7'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } core_state_t;

    typedef enum logic [3:0] {
        OP_NONE = 4'b0001,
        OP_WRITE = 4'b0010,
        OP_LOAD = 4'b0100,
        OP_NEXT = 4'b1000
    } core_op_t;
endpackage

`timescale 1ns/10ps
`default_nettype none

// Picks glyph ROM or user glyph RAM row and overlays the cursor row
module glyph_row_select (
    input wire logic [7:0] i_code,
    input wire logic [2:0] i_row,
    input wire logic [7:0] i_user_byte,
    input wire logic i_cursor_on,
    output logic [4:0] o_pixels
);
    import char_lcd_pkg::*;

    logic [4:0] rom_row;
    logic [4:0] pattern;

    // Stand-in font: a real font table replaces this constant mapping
    always_comb begin
        rom_row = i_code[4:0] ^ {2'b00, i_row}; // RL15
    end

    // Codes with a zero upper nibble show user glyphs, low five bits only
    always_comb begin
        if (i_code[7:4] == 4'h0) begin
            pattern = i_user_byte[4:0]; // RL17 RL18 RL22
        end else begin
            pattern = rom_row;
        end
        if (i_row == CURSOR_ROW) begin
            o_pixels = pattern | {5{i_cursor_on}}; // RL21
        end else begin
            o_pixels = pattern;
        end
    end
endmodule // glyph_row_select

`default_nettype wire

// *** tb/host_bus_model.sv ***
// Host processor model for the parallel register port
`timescale 1ns/10ps
`default_nettype none

module host_bus_model (
    input wire logic i_clk,
    input wire logic [7:0] i_data_out,
    output logic o_register_select,
    output logic o_read_write,
    output logic o_enable,
    output logic [7:0] o_data,
    output logic o_rd_stb,
    output logic [7:0] o_rd_val
);
    // Idle bus: strobe low, read direction, data driven to a junk 5AH pattern
    initial begin
        o_register_select = 1'b0;
        o_read_write = 1'b1;
        o_enable = 1'b0;
        o_data = 8'h5a;
        o_rd_stb = 1'b0;
        o_rd_val = 8'h00;
    end

    // Strobe held six cycles, since read data lags the pin rise
    task automatic access(input logic rs, input logic rw,
                          input logic [7:0] d, input logic chk);
        @(posedge i_clk);
        o_register_select <= rs;
        o_read_write <= rw;
        o_data <= rw ? ~o_data : d;
        o_enable <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_rd_val <= i_data_out;
        o_rd_stb <= rw & chk;
        o_enable <= 1'b0;
        @(posedge i_clk);
        o_rd_stb <= 1'b0;
        repeat (3) @(posedge i_clk);
        o_data <= ~o_data; // Released lines never keep the last value
    endtask

    // Polls status, bounded; the watchdog catches a stuck flag
    task automatic wait_idle();
        for (int n = 0; n < 60; n++) begin
            access(1'b0, 1'b1, 8'h00, 1'b0);
            if (o_rd_val[7] === 1'b0) begin
                break;
            end
        end
    endtask
endmodule // host_bus_model

`default_nettype wire

// *** tb/char_lcd_core_bench.sv ***
// Self-checking bench for the character display register core
`timescale 1ns/10ps
`default_nettype none

module char_lcd_core_bench;
    import char_lcd_pkg::*;
    logic clk, sys_rst, register_select, read_write, enable;
    logic [7:0] data_in, data_out, rd_val;
    logic data_oe, rd_stb, sc_stb, scan_line, cursor_on;
    logic [3:0] scan_col;
    logic [2:0] scan_row;
    logic [4:0] pixel_row;
    logic [7:0] exp_q[$];
    logic [7:0] d[8];
    logic [7:0] g[8];
    logic [7:0] a;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed;

    char_lcd_core char_lcd_core_i (.i_clk(clk), .i_sys_rst(sys_rst),
        .i_register_select(register_select), .i_read_write(read_write),
        .i_enable(enable), .i_data_in(data_in), .o_data_out(data_out),
        .o_data_oe(data_oe), .i_scan_line(scan_line), .i_scan_col(scan_col),
        .i_scan_row(scan_row), .i_cursor_on(cursor_on),
        .o_pixel_row(pixel_row));

    host_bus_model host_bus_model_i (.i_clk(clk), .i_data_out(data_out),
        .o_register_select(register_select), .o_read_write(read_write),
        .o_enable(enable), .o_data(data_in), .o_rd_stb(rd_stb),
        .o_rd_val(rd_val));

    // Clock at 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR result expected %h seen %h", exp, seen);
        end
    endtask

    // Oldest note is matched against each result as it appears
    always @(posedge clk) begin
        if (rd_stb === 1'b1 || sc_stb === 1'b1) begin
            check(rd_stb === 1'b1 ? rd_val : {3'h0, pixel_row},
                  exp_q.pop_front());
        end
        // The core must still drive the bus when the read is taken
        if (rd_stb === 1'b1) begin
            check({7'h00, data_oe}, 8'h01);
        end
    end

    task automatic wr(input logic rs, input logic [7:0] v);
        host_bus_model_i.access(rs, 1'b0, v, 1'b0);
        host_bus_model_i.wait_idle();
    endtask

    task automatic rd(input logic rs, input logic [7:0] e);
        exp_q.push_back(e);
        host_bus_model_i.access(rs, 1'b1, 8'h00, 1'b1);
        host_bus_model_i.wait_idle();
    endtask

    // Pixels are registered, so the result is taken two edges on
    task automatic scan(input logic ln, input logic [2:0] row,
                        input logic cur, input logic [4:0] e);
        exp_q.push_back({3'h0, e});
        @(posedge clk);
        scan_line <= ln;
        scan_row <= row;
        cursor_on <= cur;
        @(posedge clk);
        sc_stb <= 1'b1;
        @(posedge clk);
        sc_stb <= 1'b0;
    endtask

    // Watchdog sized well above the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        sc_stb = 1'b0;
        scan_line = 1'b0;
        scan_col = 4'h0;
        scan_row = 3'h0;
        cursor_on = 1'b0;
        seed = $urandom(32'h4e41a303);
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(1'b0, 8'h00);
        // Status during the transfer shows busy with the new address
        host_bus_model_i.access(1'b0, 1'b0, 8'h85, 1'b0);
        rd(1'b0, 8'h85);
        for (int i = 0; i < 3; i++) begin
            d[i] = 8'($urandom);
            wr(1'b1, d[i]);
        end
        // A second write inside the busy time must be dropped
        host_bus_model_i.access(1'b1, 1'b0, 8'h3c, 1'b0);
        host_bus_model_i.access(1'b1, 1'b0, 8'hc3, 1'b0);
        host_bus_model_i.wait_idle();
        d[3] = 8'h3c;
        rd(1'b0, 8'h09);
        wr(1'b0, 8'h85);
        for (int i = 0; i < 4; i++) begin
            rd(1'b1, d[i]);
        end
        rd(1'b0, 8'h09);
        // Cursor move right steps the counter without a RAM access
        wr(1'b0, 8'h14);
        rd(1'b0, 8'h0a);
        wr(1'b0, 8'h04);
        // An instruction inside the busy time must be dropped
        host_bus_model_i.access(1'b0, 1'b0, 8'h8a, 1'b0);
        host_bus_model_i.access(1'b0, 1'b0, 8'h06, 1'b0);
        host_bus_model_i.wait_idle();
        wr(1'b1, 8'h77);
        rd(1'b0, 8'h09);
        wr(1'b0, 8'h06);
        wr(1'b0, 8'h48);
        for (int r = 0; r < 8; r++) begin
            g[r] = (r == 7) ? 8'he0 : 8'($urandom);
            wr(1'b1, g[r]);
        end
        rd(1'b0, 8'h10);
        a = 8'($urandom);
        wr(1'b0, 8'h40);
        wr(1'b1, a);
        wr(1'b0, 8'h80);
        wr(1'b1, 8'h09);
        wr(1'b1, 8'h00);
        wr(1'b0, 8'ha7);
        wr(1'b1, 8'h01);
        wr(1'b0, 8'hc0);
        wr(1'b1, 8'h08);
        for (int r = 0; r < 8; r++) begin
            scan(1'b0, 3'(r), 1'b0, g[r][4:0]);
        end
        scan(1'b0, 3'h7, 1'b1, 5'h1f);
        scan(1'b1, 3'h0, 1'b0, a[4:0]);
        // A code with a nonzero upper nibble comes from the glyph ROM
        wr(1'b0, 8'hc3);
        wr(1'b1, 8'h35);
        scan_col <= 4'h3;
        scan(1'b1, 3'h2, 1'b0, 5'h17);
        scan_col <= 4'h0;
        wr(1'b0, 8'h18);
        scan(1'b0, 3'h0, 1'b0, a[4:0]);
        wr(1'b0, 8'h1c);
        wr(1'b0, 8'h1c);
        scan(1'b0, 3'h0, 1'b0, g[0][4:0]);
        final_report();
    end
endmodule // char_lcd_core_bench

`default_nettype wire
